// ===== hw/gpio_mux_pkg.sv
// gpio_mux_pkg: constants and carrier types for the gpio alternate mux
// assumes a single 250 MHz clock domain and no software-reached registers
package gpio_mux_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int unsigned NUM_PINS = 7;

   // pin positions of the alternate functions
   localparam int unsigned PIN_PORT2_RST = 0;
   localparam int unsigned PIN_PORT4_RST = 1;
   localparam int unsigned PIN_IRQ0 = 2;
   localparam int unsigned PIN_IRQ1 = 3;
   localparam int unsigned PIN_IRQ2 = 4;
   localparam int unsigned NUM_IRQS = 3;

   // values after reset
   localparam logic [NUM_PINS-1:0] ALT_RESET = 7'h00;
   localparam logic [NUM_PINS-1:0] DIR_RESET = 7'h00;
   localparam logic [NUM_PINS-1:0] OUT_RESET = 7'h00;
   localparam logic [NUM_PINS-1:0] OE_N_RESET = 7'h7f;

   ////////////////////////////////////////////////////////////////////////
   typedef enum {
      KIND_GPIO,
      KIND_ALT_OUT,
      KIND_ALT_IN
   } pin_kind_t;

   // software bit-io settings: dir 1 = output
   typedef struct packed {
      logic [NUM_PINS-1:0] dir;
      logic [NUM_PINS-1:0] out;
   } gpio_cfg_t;

   // one source of alternate-function enables
   typedef struct packed {
      logic valid;
      logic [NUM_PINS-1:0] value;
   } alt_load_t;

   function automatic pin_kind_t pin_kind(input int unsigned idx);
      if (idx == PIN_PORT2_RST || idx == PIN_PORT4_RST) begin
         return KIND_ALT_OUT;
      end else if (idx >= PIN_IRQ0 && idx <= PIN_IRQ2) begin
         return KIND_ALT_IN;
      end
      return KIND_GPIO;
   endfunction : pin_kind

endpackage : gpio_mux_pkg

// ===== hw/gpio_alt_function_mux.sv
// gpio_alt_function_mux: general-purpose pins 0..6, pins 0..4 with alternate functions
// assumes pin inputs synchronous to i_mclk; pad wire resolved outside
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - signals named with _n or rstn are asserted low, as are pins 0..4 in alternate mode; all others high.
// - a pin without its alternate function works as a plain bit io.
// - pin 0 in alternate mode drives the low-active port 2 reset.
// - pin 1 in alternate mode drives the low-active port 4 reset.
// - pins 2..4 in alternate mode take low-active expander irqs 0..2.
// - outside alternate mode each pin's direction is set by software, independent of others; pins 0..4 in alternate mode have a fixed direction.
// - alternate enables load from software, slave bus or config memory.
// - an expander irq makes the device request a read of hot-plug inputs.
module gpio_alt_function_mux (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic [gpio_mux_pkg::NUM_PINS-1:0] i_pin_in,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_pin_out,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_pin_oe_n,
   input wire gpio_mux_pkg::gpio_cfg_t i_gpio_cfg,
   input wire gpio_mux_pkg::alt_load_t i_alt_sw,
   input wire gpio_mux_pkg::alt_load_t i_alt_slave,
   input wire gpio_mux_pkg::alt_load_t i_alt_cfgmem,
   input wire logic i_port2_reset_req,
   input wire logic i_port4_reset_req,
   input wire logic i_hp_read_done,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_gpio_in,
   output logic [gpio_mux_pkg::NUM_PINS-1:0] o_alt_sel,
   output logic [gpio_mux_pkg::NUM_IRQS-1:0] o_expander_irq,
   output logic o_hp_read_req
);

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alternate-function enables
   logic [gpio_mux_pkg::NUM_PINS-1:0] alt_q;
   logic [gpio_mux_pkg::NUM_PINS-1:0] alt_d;

   // software wins over slave bus, slave bus over config memory load
   always_comb begin
      alt_d = alt_q;
      if (i_alt_sw.valid) begin
         alt_d = i_alt_sw.value;
      end else if (i_alt_slave.valid) begin
         alt_d = i_alt_slave.value;
      end else if (i_alt_cfgmem.valid) begin
         alt_d = i_alt_cfgmem.value;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         alt_q <= gpio_mux_pkg::ALT_RESET;
      end else begin
         alt_q <= alt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pad drive
   logic [gpio_mux_pkg::NUM_PINS-1:0] out_d;
   logic [gpio_mux_pkg::NUM_PINS-1:0] oe_n_d;
   logic [gpio_mux_pkg::NUM_PINS-1:0] out_q;
   logic [gpio_mux_pkg::NUM_PINS-1:0] oe_n_q;
   logic [gpio_mux_pkg::NUM_PINS-1:0] in_q;
   logic [gpio_mux_pkg::NUM_PINS-1:0] alt_sel_q;

   always_comb begin
      for (int unsigned i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin
         // plain bit io, each pin on its own direction bit
         out_d[i] = i_gpio_cfg.out[i];
         oe_n_d[i] = ~i_gpio_cfg.dir[i];
         if (alt_q[i]) begin
            case (gpio_mux_pkg::pin_kind(i))
               gpio_mux_pkg::KIND_ALT_OUT: begin
                  oe_n_d[i] = 1'b0;
               end
               gpio_mux_pkg::KIND_ALT_IN: begin
                  oe_n_d[i] = 1'b1;
               end
               default: begin
                  oe_n_d[i] = ~i_gpio_cfg.dir[i];
               end
            endcase
         end
      end
      // reset requests are active high inside, low on the pin
      if (alt_q[gpio_mux_pkg::PIN_PORT2_RST]) begin
         out_d[gpio_mux_pkg::PIN_PORT2_RST] = ~i_port2_reset_req;
      end
      if (alt_q[gpio_mux_pkg::PIN_PORT4_RST]) begin
         out_d[gpio_mux_pkg::PIN_PORT4_RST] = ~i_port4_reset_req;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= gpio_mux_pkg::OUT_RESET;
         oe_n_q <= gpio_mux_pkg::OE_N_RESET;
         in_q <= gpio_mux_pkg::OUT_RESET;
         alt_sel_q <= gpio_mux_pkg::ALT_RESET;
      end else begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         in_q <= i_pin_in;
         alt_sel_q <= alt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // expander interrupts and hot-plug read request
   logic [gpio_mux_pkg::NUM_IRQS-1:0] irq_d;
   logic [gpio_mux_pkg::NUM_IRQS-1:0] irq_q;
   logic [gpio_mux_pkg::NUM_IRQS-1:0] irq_rise;
   logic irq_event;
   logic req_d;
   logic req_q;

   always_comb begin
      for (int unsigned k = 0; k < gpio_mux_pkg::NUM_IRQS; k++) begin
         // low on the pin means asserted
         irq_d[k] = alt_q[gpio_mux_pkg::PIN_IRQ0 + k]
                    & ~i_pin_in[gpio_mux_pkg::PIN_IRQ0 + k];
      end
      irq_rise = irq_d & ~irq_q;
      irq_event = |irq_rise;
      // a new irq in the cycle of the done keeps the request standing
      req_d = (req_q & ~i_hp_read_done) | irq_event;
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= '0;
         req_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         req_q <= req_d;
      end
   end

   assign o_pin_out = out_q;
   assign o_pin_oe_n = oe_n_q;
   assign o_gpio_in = in_q;
   assign o_alt_sel = alt_sel_q;
   assign o_expander_irq = irq_q;
   assign o_hp_read_req = req_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_irq_polarity;
      @(posedge i_mclk) disable iff (!rst_n)
      alt_q[2] && !i_pin_in[2] |=> o_expander_irq[0];
   endproperty
   a_irq_polarity: assert property (p_irq_polarity)
      else $error("irq0 low pin not seen as asserted");

   property p_plain_io;
      @(posedge i_mclk) disable iff (!rst_n)
      !alt_q[6] |=> o_pin_oe_n[6] == !$past(i_gpio_cfg.dir[6])
                    && o_pin_out[6] == $past(i_gpio_cfg.out[6]);
   endproperty
   a_plain_io: assert property (p_plain_io)
      else $error("pin 6 not following bit io settings");

   property p_port2_reset;
      @(posedge i_mclk) disable iff (!rst_n)
      alt_q[0] |=> !o_pin_oe_n[0] && o_pin_out[0] == !$past(i_port2_reset_req);
   endproperty
   a_port2_reset: assert property (p_port2_reset)
      else $error("pin 0 not driving port 2 reset");

   property p_port4_reset;
      @(posedge i_mclk) disable iff (!rst_n)
      alt_q[1] && i_port4_reset_req |=> !o_pin_out[1] && !o_pin_oe_n[1];
   endproperty
   a_port4_reset: assert property (p_port4_reset)
      else $error("pin 1 not driving port 4 reset low");

   property p_irq_inputs;
      @(posedge i_mclk) disable iff (!rst_n)
      alt_q[4] |=> o_pin_oe_n[4] && o_expander_irq[2] == !$past(i_pin_in[4]);
   endproperty
   a_irq_inputs: assert property (p_irq_inputs)
      else $error("pin 4 not acting as irq input");

   property p_dir_indep;
      @(posedge i_mclk) disable iff (!rst_n)
      !alt_q[5] && $changed(i_gpio_cfg.dir[5]) |=> $changed(o_pin_oe_n[5]);
   endproperty
   a_dir_indep: assert property (p_dir_indep)
      else $error("pin 5 direction not applied");

   property p_alt_load;
      @(posedge i_mclk) disable iff (!rst_n)
      i_alt_sw.valid ##1 1'b1 |=> o_alt_sel == $past(i_alt_sw.value, 2);
   endproperty
   a_alt_load: assert property (p_alt_load)
      else $error("software alternate load lost");

   property p_hp_request;
      @(posedge i_mclk) disable iff (!rst_n)
      irq_event or (o_hp_read_req && !i_hp_read_done) |=> o_hp_read_req;
   endproperty
   a_hp_request: assert property (p_hp_request)
      else $error("hot-plug read request dropped");

   property p_alt_override;
      @(posedge i_mclk) disable iff (!rst_n)
      alt_q[1] && !i_gpio_cfg.dir[1] |=> !o_pin_oe_n[1];
   endproperty
   a_alt_override: assert property (p_alt_override)
      else $error("alternate output not overriding direction");

endmodule : gpio_alt_function_mux

`default_nettype wire

// ===== test/gpio_far_side.sv
// gpio_far_side: pad wires with pull-ups, port resets and hot-plug expander
// assumes pad controls of gpio_alt_function_mux on the same clock
`timescale 1ns/1ps
`default_nettype none
module gpio_far_side (
   input wire logic i_mclk,
   input wire logic [6:0] i_pin_out,
   input wire logic [6:0] i_pin_oe_n,
   input wire logic [6:0] i_ext_val,
   input wire logic [6:0] i_ext_en,
   input wire logic [2:0] i_hp_state,
   input wire logic i_hp_read,
   output logic [6:0] o_pin_level
);
   logic [2:0] last_q = 3'h0;
   logic [2:0] irq_n_q = 3'h7;
   logic [6:0] exp_n;
   always_ff @(posedge i_mclk) begin
      last_q <= i_hp_state;
      // a changed hot-plug input pulls its irq low until read
      irq_n_q <= i_hp_read ? 3'h7
         : irq_n_q & ~(last_q ^ i_hp_state);
   end
   assign exp_n = {2'h3, irq_n_q, 2'h3};
   // released lines sit at the pull-up level
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         o_pin_level[i] = !i_pin_oe_n[i] ? i_pin_out[i] : !exp_n[i] ? 1'b0 :
            i_ext_en[i] ? i_ext_val[i] : 1'b1;
      end
   end
endmodule : gpio_far_side
`default_nettype wire

// ===== test/test_gpio_alt_function_mux.sv
// test_gpio_alt_function_mux: random and corner tests of the pin mux
// assumes gpio_far_side as pads, port devices and expander
`timescale 1ns/1ps
`default_nettype none
module test_gpio_alt_function_mux;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   gpio_mux_pkg::gpio_cfg_t cfg = '0;
   gpio_mux_pkg::alt_load_t ld_sw = '0, ld_slave = '0, ld_cfg = '0;
   logic req2 = 1'b0, req4 = 1'b0, done = 1'b0, hp_read = 1'b0;
   logic [6:0] ext_val = 7'h00, ext_en = 7'h00, alt = 7'h00;
   logic [6:0] pin_level, pin_out, pin_oe_n, gpio_in, alt_sel;
   logic [2:0] hp_state = 3'h0, exp_irq;
   logic hp_req;
   logic [15:0] rnd = 16'h005b;
   int error_cnt = 0, comparisons = 0, cycles = 0;
   gpio_alt_function_mux i_gpio_alt_function_mux (.i_mclk(mclk),
      .i_rstn(rstn), .i_pin_in(pin_level), .o_pin_out(pin_out),
      .o_pin_oe_n(pin_oe_n), .i_gpio_cfg(cfg), .i_alt_sw(ld_sw),
      .i_alt_slave(ld_slave), .i_alt_cfgmem(ld_cfg),
      .i_port2_reset_req(req2), .i_port4_reset_req(req4),
      .i_hp_read_done(done), .o_gpio_in(gpio_in), .o_alt_sel(alt_sel),
      .o_expander_irq(exp_irq), .o_hp_read_req(hp_req));
   gpio_far_side i_gpio_far_side (.i_mclk(mclk), .i_pin_out(pin_out),
      .i_pin_oe_n(pin_oe_n), .i_ext_val(ext_val), .i_ext_en(ext_en),
      .i_hp_state(hp_state), .i_hp_read(hp_read), .o_pin_level(pin_level));
   initial begin
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   function automatic logic [6:0] exp_oe_n();
      return (~cfg.dir & ~(alt & 7'h03)) | (alt & 7'h1c);
   endfunction : exp_oe_n
   function automatic logic [6:0] exp_out();
      return {cfg.out[6:2], alt[1] ? ~req4 : cfg.out[1],
         alt[0] ? ~req2 : cfg.out[0]};
   endfunction : exp_out
   function automatic logic [6:0] exp_lvl();
      return (~exp_oe_n() & exp_out()) |
         (exp_oe_n() & ((ext_en & ext_val) | ~ext_en));
   endfunction : exp_lvl
   task automatic chk(input logic [6:0] got, input logic [6:0] exp,
      input logic [6:0] msk, input string what);
      comparisons++;
      if ((got & msk) !== (exp & msk)) begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic load(input logic [2:0] w, input logic [6:0] v);
      @(negedge mclk);
      ld_sw = {w[0], v};
      ld_slave = {w[1], ~v};
      ld_cfg = {w[2], v ^ 7'h55};
      alt = w[0] ? v : (w[1] ? ~v : v ^ 7'h55);
      @(negedge mclk);
      ld_sw = '0;
      ld_slave = '0;
      ld_cfg = '0;
      repeat (3) @(negedge mclk);
      chk(alt_sel, alt, 7'h7f, "alt");
   endtask : load
   task automatic step();
      @(negedge mclk);
      rnd = lfsr(rnd);
      {cfg.dir, cfg.out, req2, req4} = rnd;
      rnd = lfsr(rnd);
      ext_val = rnd[6:0];
      ext_en = rnd[13:7] & ~cfg.dir;
      repeat (4) @(negedge mclk);
      chk(pin_oe_n, exp_oe_n(), 7'h7f, "oe");
      chk(pin_out, exp_out(), ~exp_oe_n(), "out");
      chk(gpio_in, exp_lvl(), 7'h7f, "in");
   endtask : step
   task automatic irq(input int k, input logic en);
      @(negedge mclk);
      cfg.dir = 7'h00;
      ext_en = 7'h00;
      hp_state[k] = ~hp_state[k];
      repeat (4) @(negedge mclk);
      chk({4'h0, exp_irq}, {6'h00, en} << k, 7'h07, "irq");
      chk({6'h00, hp_req}, {6'h00, en}, 7'h01, "req");
      done = 1'b1;
      @(negedge mclk);
      done = 1'b0;
      repeat (3) @(negedge mclk);
      chk({6'h00, hp_req}, 7'h00, 7'h01, "held");
      hp_read = 1'b1;
      @(negedge mclk);
      hp_read = 1'b0;
      repeat (3) @(negedge mclk);
      chk({4'h0, exp_irq}, 7'h00, 7'h07, "clear");
   endtask : irq
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge mclk);
      chk(pin_oe_n, 7'h7f, 7'h7f, "reset oe");
      chk(pin_out, 7'h00, 7'h7f, "reset out");
      chk(alt_sel, 7'h00, 7'h7f, "reset alt");
      chk({3'h0, hp_req, exp_irq}, 7'h00, 7'h0f, "reset irq");
      rstn = 1'b1;
      repeat (3) @(negedge mclk);
      repeat (12) step();
      $display("gpio test done");
      for (int w = 1; w < 8; w++) begin
         rnd = lfsr(rnd);
         load(w[2:0], rnd[6:0]);
         repeat (3) step();
      end
      load(3'h1, 7'h7f);
      repeat (12) step();
      $display("alternate test done");
      load(3'h2, 7'h63);
      for (int k = 0; k < 3; k++) begin
         irq(k, 1'b1);
      end
      load(3'h1, 7'h00);
      irq(1, 1'b0);
      $display("irq test done");
      give_verdict();
   end
endmodule : test_gpio_alt_function_mux
`default_nettype wire
